// [common/svd_pkg.sv]
// Package for the supply voltage detect block: register map, field layout, resets.
// Assumes an Avalon-MM slave with 32-bit data and byte addresses.
package svd_pkg;
    localparam int unsigned ADDR_W          = 8;
    localparam int unsigned DATA_W          = 32;
    localparam int unsigned REG_W           = 8;
    // Register byte addresses
    localparam logic [7:0]  CTRL_STATUS_ADDR = 8'h0c;
    localparam logic [7:0]  ALARM_ADDR       = 8'h10;
    localparam logic [7:0]  MODE_ADDR        = 8'h14;
    // Field positions in supply_detect_ctrl_status
    localparam int unsigned EN_BIT          = 0;
    localparam int unsigned LOW_BIT         = 1;
    localparam int unsigned HIGH_BIT        = 2;
    // Field positions in the alarm register (request, mask, pending)
    localparam int unsigned REQ_BIT         = 5;
    localparam int unsigned MASK_BIT        = 0;
    localparam int unsigned PEND_BIT        = 1;
    // Field position in the mode register
    localparam int unsigned STOP_BIT        = 0;
    localparam logic        EN_RESET        = 1'b0;
    localparam logic        FLAG_RESET      = 1'b0;
    localparam logic        MASK_RESET      = 1'b0;
    localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;
endpackage

// [core/svd_sync.sv]
// Two-stage synchroniser for the comparator levels.
// Assumes inputs come from analog logic asynchronous to i_clock.
`timescale 1ns/1ps
module svd_sync
#(
    parameter int unsigned WIDTH = 2
)
(
    input  wire logic             i_clock,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            always_ff @(posedge i_clock)
            begin
                if (i_reset)
                begin
                    meta_q[g] <= 1'b0;
                    sync_q[g] <= 1'b0;
                end
                else
                begin
                    meta_q[g] <= i_async[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    assign o_sync = sync_q;
endmodule

// [core/svd_core.sv]
// Supply voltage detect block: enable bit, live high/low supply flags, latched alarm.
// Assumes an Avalon-MM master on i_clock and analog comparators on the inputs.
// Functional notes
// R1 - Detection runs only while enable bit 0 is set; it resets cleared.
// R2 - When enabled, flags follow comparators continuously without software command.
// R3 - Read-only high flag at bit 2, set while supply above upper threshold.
// R4 - Read-only low flag at bit 1, set while supply below lower threshold.
// R5 - Enabled low flag sets alarm request bit five.
// R6 - Alarm request stays latched until software clears it or reset.
// R7 - Alarm is an interrupt only when its mask bit is enabled.
// R8 - Masked-off alarm still latches and reads as status.
// R9 - No detection in stop mode; flags and alarm freeze. Here software can still clear the alarm and, by disable, the flags.
// R10 - Software should enable interrupts before setting detection enable.
// R11 - Software should not rewrite port 0/1 mode while checking low supply.
// R12 - Bits 7..3 reserved: writes ignored, read zero.
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
module svd_core
(
    input  wire logic        i_clock,
    input  wire logic        i_reset,
    input  wire logic [7:0]  i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_writedata,
    input  wire logic [3:0]  i_byteenable,
    output logic      [31:0] o_readdata,
    output logic             o_waitrequest,
    input  wire logic        i_above_upper,
    input  wire logic        i_below_lower,
    output logic             o_supply_alarm_irq
);
    logic [1:0]  cmp_sync;
    logic        supply_detect_enable_q;
    logic        high_supply_flag_q;
    logic        low_supply_flag_q;
    logic        supply_alarm_request_q;
    logic        alarm_mask_q;
    logic        stop_mode_q;
    logic        ack_q;
    logic [31:0] readdata_q;
    logic        wr_go;
    logic        rd_go;
    logic        detect_live;
    logic        alarm_clear;

    svd_sync #(.WIDTH(2)) u_svd_sync
    (
        .i_clock (i_clock),
        .i_reset (i_reset),
        .i_async ({i_above_upper, i_below_lower}),
        .o_sync  (cmp_sync)
    );

    // One wait cycle per access: write taken on the edge where ack_q is high, read on the edge before it
    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            ack_q <= 1'b0;
        else if ((i_read || i_write) && !ack_q)
            ack_q <= 1'b1;
        else
            ack_q <= 1'b0;
    end

    assign o_waitrequest = (i_read || i_write) && !ack_q;
    assign wr_go         = i_write && ack_q && i_byteenable[0];
    assign rd_go         = i_read && !ack_q;
    assign detect_live   = supply_detect_enable_q && !stop_mode_q; // R1 R9
    assign alarm_clear   = wr_go && (i_address == svd_pkg::ALARM_ADDR)
                           && !i_writedata[svd_pkg::REQ_BIT];

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            supply_detect_enable_q <= svd_pkg::EN_RESET; // R1
        else if (wr_go && i_address == svd_pkg::CTRL_STATUS_ADDR)
            supply_detect_enable_q <= i_writedata[svd_pkg::EN_BIT]; // R1 R12
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            alarm_mask_q <= svd_pkg::MASK_RESET;
            stop_mode_q  <= 1'b0;
        end
        else if (wr_go && i_address == svd_pkg::ALARM_ADDR)
            alarm_mask_q <= i_writedata[svd_pkg::MASK_BIT];
        else if (wr_go && i_address == svd_pkg::MODE_ADDR)
            stop_mode_q <= i_writedata[svd_pkg::STOP_BIT];
    end

    // Flags track the comparators each cycle; frozen in stop, cleared when disabled
    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            high_supply_flag_q <= svd_pkg::FLAG_RESET; // R3
            low_supply_flag_q  <= svd_pkg::FLAG_RESET; // R4
        end
        else if (!supply_detect_enable_q)
        begin
            high_supply_flag_q <= svd_pkg::FLAG_RESET;
            low_supply_flag_q  <= svd_pkg::FLAG_RESET;
        end
        else if (!stop_mode_q) // R9
        begin
            high_supply_flag_q <= cmp_sync[1]; // R2 R3
            low_supply_flag_q  <= cmp_sync[0]; // R2 R4
        end
    end

    // Latched alarm; a new event wins over a clear in the same cycle
    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            supply_alarm_request_q <= 1'b0;
        else if (detect_live && low_supply_flag_q)
            supply_alarm_request_q <= 1'b1; // R5 R6 R8
        else if (alarm_clear)
            supply_alarm_request_q <= 1'b0; // R6
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            o_supply_alarm_irq <= 1'b0;
        else
            o_supply_alarm_irq <= supply_alarm_request_q && alarm_mask_q; // R7 R8
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            readdata_q <= svd_pkg::UNMAPPED_DATA;
        else if (rd_go)
        begin
            readdata_q <= svd_pkg::UNMAPPED_DATA;
            case (i_address)
                svd_pkg::CTRL_STATUS_ADDR:
                begin
                    readdata_q[svd_pkg::EN_BIT]   <= supply_detect_enable_q;
                    readdata_q[svd_pkg::LOW_BIT]  <= low_supply_flag_q;  // R4
                    readdata_q[svd_pkg::HIGH_BIT] <= high_supply_flag_q; // R3 R12
                end
                svd_pkg::ALARM_ADDR:
                begin
                    readdata_q[svd_pkg::MASK_BIT] <= alarm_mask_q;
                    readdata_q[svd_pkg::PEND_BIT] <= o_supply_alarm_irq;
                    readdata_q[svd_pkg::REQ_BIT]  <= supply_alarm_request_q; // R8
                end
                svd_pkg::MODE_ADDR:
                    readdata_q[svd_pkg::STOP_BIT] <= stop_mode_q;
                default:
                    readdata_q <= svd_pkg::UNMAPPED_DATA;
            endcase
        end
    end

    assign o_readdata = readdata_q;

    // Each label line except wait_one_a carries the tag of the rule checked beneath it
    enable_reset_a: assert property // R1
        (@(posedge i_clock) $fell(i_reset) |-> !supply_detect_enable_q)
        else $error("Enable not cleared after reset");
    flags_off_a: assert property // R1
        (@(posedge i_clock) disable iff (i_reset)
        !$past(supply_detect_enable_q) |-> !high_supply_flag_q && !low_supply_flag_q)
        else $error("Flags set while detection disabled");
    track_low_a: assert property // R2
        (@(posedge i_clock) disable iff (i_reset)
        $past(detect_live) |-> low_supply_flag_q == $past(cmp_sync[0]))
        else $error("Low flag not tracking comparator");
    track_high_a: assert property // R2
        (@(posedge i_clock) disable iff (i_reset)
        $past(detect_live) |-> high_supply_flag_q == $past(cmp_sync[1]))
        else $error("High flag not tracking comparator");
    high_flag_a: assert property // R3
        (@(posedge i_clock) disable iff (i_reset)
        high_supply_flag_q |-> $past(cmp_sync[1]) || $past(stop_mode_q))
        else $error("High flag set without comparator");
    low_flag_a: assert property // R4
        (@(posedge i_clock) disable iff (i_reset)
        low_supply_flag_q |-> $past(cmp_sync[0]) || $past(stop_mode_q))
        else $error("Low flag set without comparator");
    alarm_set_a: assert property // R5
        (@(posedge i_clock) disable iff (i_reset)
        detect_live && low_supply_flag_q |=> supply_alarm_request_q)
        else $error("Alarm not set by low flag");
    alarm_hold_a: assert property // R6
        (@(posedge i_clock) disable iff (i_reset)
        supply_alarm_request_q && !alarm_clear |=> supply_alarm_request_q)
        else $error("Alarm dropped without clear");
    irq_mask_a: assert property // R7
        (@(posedge i_clock) disable iff (i_reset)
        o_supply_alarm_irq == $past(supply_alarm_request_q && alarm_mask_q))
        else $error("Interrupt not gated by mask");
    masked_quiet_a: assert property // R7
        (@(posedge i_clock) disable iff (i_reset)
        !alarm_mask_q |=> !o_supply_alarm_irq)
        else $error("Interrupt raised while masked");
    stop_freeze_a: assert property // R9
        (@(posedge i_clock) disable iff (i_reset)
        $past(stop_mode_q) && $past(supply_detect_enable_q)
        |-> $stable(low_supply_flag_q) && $stable(high_supply_flag_q))
        else $error("Flag changed in stop mode");
    stop_alarm_a: assert property // R9
        (@(posedge i_clock) disable iff (i_reset)
        stop_mode_q && !supply_alarm_request_q |=> !supply_alarm_request_q)
        else $error("Alarm set in stop mode");
    reserved_zero_a: assert property // R12
        (@(posedge i_clock) disable iff (i_reset)
        $past(rd_go && i_address == svd_pkg::CTRL_STATUS_ADDR)
        |-> o_readdata[svd_pkg::DATA_W-1:svd_pkg::HIGH_BIT+1] == '0)
        else $error("Reserved bits not read as zero");
    wait_one_a: assert property
        (@(posedge i_clock) disable iff (i_reset)
        o_waitrequest |=> !o_waitrequest)
        else $error("Waitrequest held too long");

    alarm_seen_c: cover property (@(posedge i_clock) $rose(supply_alarm_request_q));
    irq_seen_c: cover property (@(posedge i_clock) $rose(o_supply_alarm_irq));
    clear_seen_c: cover property (@(posedge i_clock) $fell(supply_alarm_request_q));
    high_seen_c: cover property (@(posedge i_clock) $rose(high_supply_flag_q));
    stop_low_c: cover property (@(posedge i_clock) stop_mode_q && low_supply_flag_q);
endmodule

// [tb/svd_cmp_model.sv]
// Model of the analog supply comparators beside the detect block.
// Assumes the bench drives a supply level code; thresholds are plain defaults.
`timescale 1ns/1ps
module svd_cmp_model
#(
    parameter logic [7:0] UPPER_LEVEL = 8'hc0,
    parameter logic [7:0] LOWER_LEVEL = 8'h40
)
(
    input  wire logic [7:0] i_supply_level,
    output logic            o_above_upper,
    output logic            o_below_lower
);
    assign o_above_upper = (i_supply_level > UPPER_LEVEL);
    // Levels are clean: no port switching noise reaches the low comparator
    assign o_below_lower = (i_supply_level < LOWER_LEVEL);
endmodule

// [tb/svd_core_bench.sv]
// Self-checking bench for svd_core: Avalon-MM master tasks, comparator model, row table.
// Assumes svd_pkg, the design files and the comparator model are compiled first.
`timescale 1ns/1ps
module svd_core_bench;
    typedef struct {
        logic [7:0]  lvl;
        logic [31:0] ctrl;
        logic [31:0] mode;
        logic [31:0] exp;
    } svd_row_t;
    logic        clock;
    logic        reset;
    logic [7:0]  address;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    logic        waitreq;
    logic        above;
    logic        below;
    logic        irq;
    logic [7:0]  level;
    logic [31:0] got;
    int          failures;
    int          num_checks;
    // Level, enable, stop, expected status; order matters for the stop row
    svd_row_t rows [6] = '{'{8'h20, 32'h0, 32'h0, 32'h00}, '{8'h80, 32'h1, 32'h0, 32'h01},
        '{8'hf0, 32'h1, 32'h0, 32'h05}, '{8'h20, 32'h1, 32'h0, 32'h03},
        '{8'h80, 32'h1, 32'h1, 32'h03}, '{8'h80, 32'h1, 32'h0, 32'h01}};

    svd_cmp_model u_svd_cmp_model (.i_supply_level(level), .o_above_upper(above),
        .o_below_lower(below));
    svd_core u_svd_core (.i_clock(clock), .i_reset(reset), .i_address(address), .i_read(rd),
        .i_write(wr), .i_writedata(wdata), .i_byteenable(be), .o_readdata(rdata),
        .o_waitrequest(waitreq), .i_above_upper(above), .i_below_lower(below),
        .o_supply_alarm_irq(irq));

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic complete_run();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
            failures++;
        end
    endtask

    task automatic chk_bit(input logic g, input logic e);
        num_checks++;
        if (g !== e)
        begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
            failures++;
        end
    endtask

    // One bus cycle; held until waitrequest is sampled low, data taken at that edge
    task automatic bus(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        address <= a;
        wdata <= d;
        rd <= !is_wr;
        wr <= is_wr;
        @(posedge clock);
        while (waitreq !== 1'b0 && n < 20)
        begin
            n++;
            @(posedge clock);
        end
        got = rdata;
        if (n == 20)
        begin
            failures++;
            complete_run();
        end
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clock);
    endtask

    task automatic settle(input logic [7:0] l);
        level <= l;
        repeat (6) @(posedge clock);
    endtask

    initial
    begin
        reset = 1'b1;
        address = 8'h00;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0;
        be = 4'h1;
        level = 8'h80;
        failures = 0;
        num_checks = 0;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        bus(1'b0, svd_pkg::CTRL_STATUS_ADDR, 32'h0);
        chk_data(got, 32'h0);
        bus(1'b0, svd_pkg::ALARM_ADDR, 32'h0);
        chk_data(got, 32'h0);
        foreach (rows[i])
        begin
            bus(1'b1, svd_pkg::MODE_ADDR, rows[i].mode);
            bus(1'b1, svd_pkg::CTRL_STATUS_ADDR, rows[i].ctrl);
            settle(rows[i].lvl);
            bus(1'b0, svd_pkg::CTRL_STATUS_ADDR, 32'h0);
            chk_data(got, rows[i].exp);
        end
        bus(1'b1, svd_pkg::CTRL_STATUS_ADDR, 32'hff);
        bus(1'b0, svd_pkg::CTRL_STATUS_ADDR, 32'h0);
        chk_data(got, 32'h01);
        be <= 4'h0;
        bus(1'b1, svd_pkg::CTRL_STATUS_ADDR, 32'h0);
        be <= 4'h1;
        bus(1'b0, svd_pkg::CTRL_STATUS_ADDR, 32'h0);
        chk_data(got, 32'h01);
        bus(1'b0, 8'h20, 32'h0);
        chk_data(got, svd_pkg::UNMAPPED_DATA);
        // Mask first, then enable, so a low supply raises the interrupt
        bus(1'b1, svd_pkg::CTRL_STATUS_ADDR, 32'h0);
        bus(1'b1, svd_pkg::ALARM_ADDR, 32'h01);
        bus(1'b1, svd_pkg::CTRL_STATUS_ADDR, 32'h1);
        settle(8'h20);
        chk_bit(irq, 1'b1);
        bus(1'b0, svd_pkg::ALARM_ADDR, 32'h0);
        chk_data(got, 32'h23);
        settle(8'h80);
        bus(1'b0, svd_pkg::ALARM_ADDR, 32'h0);
        chk_data(got, 32'h23);
        bus(1'b1, svd_pkg::ALARM_ADDR, 32'h0);
        bus(1'b0, svd_pkg::ALARM_ADDR, 32'h0);
        chk_data(got, 32'h0);
        settle(8'h20);
        chk_bit(irq, 1'b0);
        bus(1'b0, svd_pkg::ALARM_ADDR, 32'h0);
        chk_data(got, 32'h20);
        // Clear while the low event is still live: the set wins
        bus(1'b1, svd_pkg::ALARM_ADDR, 32'h0);
        bus(1'b0, svd_pkg::ALARM_ADDR, 32'h0);
        chk_data(got, 32'h20);
        // Stop mode: the cleared alarm stays clear under a low supply
        bus(1'b1, svd_pkg::MODE_ADDR, 32'h1);
        bus(1'b1, svd_pkg::ALARM_ADDR, 32'h0);
        settle(8'h20);
        bus(1'b0, svd_pkg::ALARM_ADDR, 32'h0);
        chk_data(got, 32'h0);
        bus(1'b0, svd_pkg::CTRL_STATUS_ADDR, 32'h0);
        chk_data(got, 32'h03);
        bus(1'b0, svd_pkg::MODE_ADDR, 32'h0);
        chk_data(got, 32'h01);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        bus(1'b0, svd_pkg::ALARM_ADDR, 32'h0);
        chk_data(got, 32'h0);
        bus(1'b0, svd_pkg::CTRL_STATUS_ADDR, 32'h0);
        chk_data(got, 32'h0);
        bus(1'b0, svd_pkg::MODE_ADDR, 32'h0);
        chk_data(got, 32'h0);
        complete_run();
    end
endmodule
